// ===== core/tsb_pkg.sv
// Shared constants, message types and window decoding for the shared-area bus station.
// Assumes a single 10 MHz core clock and an error-free message stream between stations.
// Overview of operation
// - Only token and data broadcast messages exist
// - Master starts with token, polls slaves cyclically
// - Slaves never pass token; master issues each
// - Station zero master, station one standby master
// - At most 32 stations, 16 per layer
// - Bridge node uses two ports, two layers
// - Fixed area: 64 words, 512 bits
// - Broadcast own window, store others read-only
// - Mode 1: 32 stations, 2 words, 16 bits
// - Mode 2: 16 stations, 4 words, 32 bits
// - Modes 6-9 map lower half, layer 0
// - Modes 10-13 map upper half, layer 1
// - Missing station does not stop the exchange
// - Online settings change, new stations auto-joined
// - Status flags report whole-network state
// - Network settings come from station zero
// - Link is an RS485 line, one port
// - Mode 3: 8 stations, 8 words, 64 bits
// - Joining station detected within one second
// - Only stations below the maximum broadcast
// - Lowest present station number is master
package tsb_pkg;

	localparam int unsigned STN_W = 5;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned MODE_W = 5;
	localparam int unsigned WORDS = 64;
	localparam int unsigned CHUNKS = 32;
	localparam int unsigned MAX_SINGLE = 32;
	localparam int unsigned MAX_LAYER = 16;
	localparam int unsigned TMR_W = 32;
	localparam logic [5:0] LAYER1_BASE = 6'h20;
	localparam logic [11:0] WIN_WORDS_MIN = 12'h002;
	localparam logic [6:0] ITEM_UNIT = 7'h03;
	localparam int unsigned TOK_MAX_LSB = 0;
	localparam int unsigned TOK_MODE_LSB = 6;

	// Timing: poll timeout is a least wait, rounded up
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned POLL_TIMEOUT_US = 20000;
	localparam int unsigned SILENCE_US = 50000;
	localparam int unsigned POLL_CYC = (POLL_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SILENCE_CYC = (SILENCE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Two message kinds only
	typedef enum logic {TSB_TOKEN, TSB_DATA} tsb_kind_t;

	typedef struct packed
	{
		tsb_kind_t kind;
		logic [STN_W-1:0] src;
		logic [STN_W-1:0] dst;
		logic [DATA_W-1:0] data;
		logic last;
	} tsb_msg_t;

	localparam int unsigned MSG_W = $bits(tsb_msg_t);

	// Window size as a shift of the smallest window
	function automatic logic [2:0] mode_shift(input logic [MODE_W-1:0] m);
		logic [4:0] s;
		s = 5'h00;
		if (m >= 5'h01 && m <= 5'h05)
			s = m - 5'h01;
		else if (m >= 5'h06 && m <= 5'h09)
			s = m - 5'h06;
		else if (m >= 5'h0a && m <= 5'h0d)
			s = m - 5'h0a;
		mode_shift = s[2:0];
	endfunction

	// First word of the mapped region
	function automatic logic [5:0] mode_base(input logic [MODE_W-1:0] m);
		mode_base = (m >= 5'h0a && m <= 5'h0d) ? LAYER1_BASE : 6'h00;
	endfunction

	// Stations sharing the region; zero for unknown modes
	function automatic logic [5:0] mode_cap(input logic [MODE_W-1:0] m);
		logic [2:0] k;
		k = mode_shift(m);
		if (m >= 5'h01 && m <= 5'h05)
			mode_cap = 6'(MAX_SINGLE >> k);
		else if (m >= 5'h06 && m <= 5'h0d)
			mode_cap = 6'(MAX_LAYER >> k);
		else
			mode_cap = 6'h00;
	endfunction

	// Item idx of station window: words first, then bit chunks
	function automatic logic [6:0] item_addr(input logic [2:0] k, input logic [5:0] base,
		input logic [STN_W-1:0] stn, input logic [5:0] idx);
		logic [11:0] wcnt;
		logic [11:0] a;
		logic chunk;
		wcnt = WIN_WORDS_MIN << k;
		chunk = ({6'h00, idx} >= wcnt);
		if (!chunk)
			a = {6'h00, base} + ({7'h00, stn} << (k + 3'h1)) + {6'h00, idx};
		else
			a = {7'h00, base[5:1]} + ({7'h00, stn} << k) + {6'h00, idx} - wcnt;
		item_addr = {chunk, a[5:0]};
	endfunction

endpackage

// ===== core/tsb_link.sv
// Message link between two stations, one channel each way.
// Assumes the line driver and framing sit outside; each beat is one message word.
`timescale 1ns/1ns
// Half-duplex line abstracted to two valid/ready channels
interface tsb_link;
	import tsb_pkg::*;
	tsb_msg_t dn_msg;
	logic dn_valid;
	logic dn_ready;
	tsb_msg_t up_msg;
	logic up_valid;
	logic up_ready;

	modport station (output dn_msg, output dn_valid, input dn_ready,
		input up_msg, input up_valid, output up_ready);
	modport peer (input dn_msg, input dn_valid, output dn_ready,
		output up_msg, output up_valid, input up_ready);
endinterface

// ===== core/tsb_buf2.sv
// Small FIFO with valid/ready on both sides, flags held in registers.
// Assumes one clock; a push and pop in the same cycle are both taken.
`timescale 1ns/1ns
module tsb_buf2
	import tsb_pkg::*;
#(
	parameter int unsigned WIDTH = MSG_W,
	parameter int unsigned DEPTH = 2
)
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] DEPTH_C = (PW + 1)'(DEPTH);
	localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [PW:0] cnt_q;
	logic ready_q;
	logic empty_q;
	logic push;
	logic pop;
	logic [PW:0] cnt_d;

	assign push = in_valid && ready_q;
	assign pop = out_ready && !empty_q;
	assign cnt_d = cnt_q + (PW + 1)'(push) - (PW + 1)'(pop);
	assign in_ready = ready_q; // straight from a flip-flop, no inverter on the link
	assign out_valid = !empty_q;
	assign out_data = mem_q[rd_q];

	// Storage, no reset needed on data
	always_ff @(posedge core_clk)
	begin
		if (push)
			mem_q[wr_q] <= in_data;
	end

	// Pointers and registered flags
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			ready_q <= 1'b1;
			empty_q <= 1'b1;
		end
		else
		begin
			if (push)
				wr_q <= (wr_q == LAST_C) ? '0 : wr_q + PW'(1);
			if (pop)
				rd_q <= (rd_q == LAST_C) ? '0 : rd_q + PW'(1);
			cnt_q <= cnt_d;
			ready_q <= (cnt_d != DEPTH_C);
			empty_q <= (cnt_d == '0);
		end
	end
endmodule

// ===== core/tsb_peer.sv
// Minimal far station: answers its token with a user-fed broadcast.
// Assumes the user supplies exactly the window's item count per token.
`timescale 1ns/1ns
module tsb_peer
	import tsb_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	tsb_link.peer link,
	input wire logic [STN_W-1:0] station_no,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [DATA_W-1:0] tx_data,
	output logic rx_valid,
	output tsb_msg_t rx_msg,
	output logic tok_mine
);
	typedef enum logic {P_IDLE, P_SEND} tsb_pstate_t;

	tsb_pstate_t state_q;
	tsb_msg_t up_msg_q;
	tsb_msg_t rx_msg_q;
	logic up_valid_q;
	logic dn_ready_q;
	logic tx_ready_q;
	logic rx_valid_q;
	logic tok_mine_q;
	logic [6:0] left_q;
	logic take;
	logic got;
	logic mine;
	logic [MODE_W-1:0] tok_mode;

	assign link.up_msg = up_msg_q;
	assign link.up_valid = up_valid_q;
	assign link.dn_ready = dn_ready_q;
	assign tx_ready = tx_ready_q;
	assign rx_valid = rx_valid_q;
	assign rx_msg = rx_msg_q;
	assign tok_mine = tok_mine_q;
	assign take = tx_valid && tx_ready_q;
	assign got = link.dn_valid && dn_ready_q;
	assign tok_mode = link.dn_msg.data[TOK_MODE_LSB +: MODE_W];
	assign mine = got && link.dn_msg.kind == TSB_TOKEN && link.dn_msg.dst == station_no;

	// Every received beat is shown to the user for one cycle
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dn_ready_q <= 1'b0;
			rx_valid_q <= 1'b0;
			rx_msg_q <= '0;
			tok_mine_q <= 1'b0;
		end
		else
		begin
			dn_ready_q <= 1'b1;
			rx_valid_q <= got;
			tok_mine_q <= mine;
			if (got)
				rx_msg_q <= link.dn_msg;
		end
	end

	// Own broadcast after own token; token is never forwarded
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= P_IDLE;
			left_q <= '0;
			tx_ready_q <= 1'b0;
			up_valid_q <= 1'b0;
			up_msg_q <= '0;
		end
		else
		begin
			unique case (state_q)
				P_IDLE:
				begin
					if (mine)
					begin
						left_q <= ITEM_UNIT << mode_shift(tok_mode);
						tx_ready_q <= 1'b1;
						state_q <= P_SEND;
					end
				end
				P_SEND:
				begin
					if (up_valid_q && link.up_ready)
						up_valid_q <= 1'b0;
					if (take)
					begin
						tx_ready_q <= 1'b0;
						up_valid_q <= 1'b1;
						up_msg_q <= '{TSB_DATA, station_no, station_no, tx_data, left_q == 7'h01};
						left_q <= left_q - 7'h01;
					end
					else if (!tx_ready_q && (!up_valid_q || link.up_ready))
					begin
						tx_ready_q <= (left_q != '0);
						if (left_q == '0)
							state_q <= P_IDLE;
					end
				end
			endcase
		end
	end
endmodule

// ===== core/tsb_station.sv
// Shared-area station: token master or slave, send and receive windows.
// Assumes settings inputs are on core_clk; link beats arrive in order.
`timescale 1ns/1ns
module tsb_station
	import tsb_pkg::*;
#(
	parameter int unsigned POLL_CYCLES = POLL_CYC,
	parameter int unsigned SILENCE_CYCLES = SILENCE_CYC
)
(
	input wire logic core_clk,
	input wire logic rst_n,
	tsb_link.station link,
	input wire logic [STN_W-1:0] cfg_station,
	input wire logic [MODE_W-1:0] cfg_mode,
	input wire logic [5:0] cfg_max,
	input wire logic usr_wr,
	input wire logic usr_bit,
	input wire logic [5:0] usr_addr,
	input wire logic [DATA_W-1:0] usr_wdata,
	output logic usr_wr_err,
	output logic [DATA_W-1:0] usr_rdata,
	output logic stat_master,
	output logic stat_token,
	output logic stat_net_ok,
	output logic [MAX_SINGLE-1:0] stat_present,
	output logic [MODE_W-1:0] stat_mode
);
	typedef enum logic [2:0] {S_START, S_IDLE, S_TX, S_NEXT, S_TOK, S_WAIT} tsb_state_t;

	localparam logic [TMR_W-1:0] POLL_C = TMR_W'(POLL_CYCLES);

	tsb_state_t state_q;
	logic [DATA_W-1:0] word_q [WORDS];
	logic [DATA_W-1:0] chunk_q [CHUNKS];
	logic master_q;
	logic [MODE_W-1:0] mode_q;
	logic [5:0] max_q;
	logic [5:0] poll_q;
	logic [5:0] item_q;
	logic [5:0] rx_idx_q;
	logic [TMR_W-1:0] tmr_q;
	logic [TMR_W-1:0] sil_q;
	tsb_msg_t dn_msg_q;
	logic dn_valid_q;
	logic err_q;
	logic [DATA_W-1:0] rdata_q;
	logic net_ok_q;
	logic token_q;
	logic [MAX_SINGLE-1:0] present_q;

	////////////////////////////////////////////////////////////////////////////////
	// Window decode
	tsb_msg_t f_msg;
	logic f_valid;
	logic f_ready;
	logic pop;
	logic [2:0] k;
	logic [5:0] base;
	logic [5:0] lim;
	logic [5:0] items;
	logic own_ok;
	logic [6:0] tx_a;
	logic [6:0] rx_a;
	logic [6:0] us_lo;
	logic [6:0] us_hi;
	logic [6:0] us_a;
	logic wr_ok;
	logic rx_store;
	logic rx_done;
	logic rx_yield;
	logic tok_me;
	logic tok_set;
	logic wait_ok;
	logic wait_tmo;
	logic cycle_start;
	logic [TMR_W-1:0] sil_lim;
	logic [MAX_SINGLE-1:0] lim_mask;

	assign k = mode_shift(mode_q);
	// A bridge node is two stations, one per layer, each on its own port
	assign base = mode_base(mode_q);
	assign lim = (mode_cap(mode_q) < max_q) ? mode_cap(mode_q) : max_q;
	assign items = 6'((ITEM_UNIT << k) - 7'h01);
	assign own_ok = ({1'b0, cfg_station} < lim);
	assign tx_a = item_addr(k, base, cfg_station, item_q);
	assign rx_a = item_addr(k, base, f_msg.src, rx_idx_q);
	// Own window span in the addressed area: first item and one past last
	assign us_lo = item_addr(k, base, cfg_station, usr_bit ? 6'(WIN_WORDS_MIN << k) : 6'h00);
	assign us_hi = us_lo + (usr_bit ? 7'(7'h01 << k) : 7'(WIN_WORDS_MIN << k));
	assign us_a = {usr_bit, usr_addr};
	assign wr_ok = usr_wr && own_ok && us_a >= us_lo && us_a < us_hi;
	assign f_ready = !usr_wr; // user write owns the storage port
	assign pop = f_valid && f_ready;
	assign rx_store = pop && f_msg.kind == TSB_DATA && f_msg.src != cfg_station
		&& {1'b0, f_msg.src} < mode_cap(mode_q) && rx_idx_q <= items;
	assign rx_done = pop && f_msg.kind == TSB_DATA && f_msg.last;
	assign tok_me = pop && f_msg.kind == TSB_TOKEN && f_msg.dst == cfg_station;
	assign tok_set = pop && f_msg.kind == TSB_TOKEN && cfg_station != '0;
	assign rx_yield = pop && f_msg.kind == TSB_TOKEN && f_msg.src < cfg_station;
	assign wait_ok = state_q == S_WAIT && rx_done && {1'b0, f_msg.src} == poll_q;
	assign wait_tmo = state_q == S_WAIT && !wait_ok && tmr_q >= POLL_C;
	assign cycle_start = state_q == S_NEXT && poll_q >= lim;
	assign sil_lim = TMR_W'(({27'h0, cfg_station} + 32'h1) * SILENCE_CYCLES);
	assign lim_mask = (lim >= 6'(MAX_SINGLE)) ? '1 : ((MAX_SINGLE)'(1) << lim) - 1'b1;

	assign link.dn_msg = dn_msg_q;
	assign link.dn_valid = dn_valid_q;
	assign usr_wr_err = err_q;
	assign usr_rdata = rdata_q;
	assign stat_master = master_q;
	assign stat_token = token_q;
	assign stat_net_ok = net_ok_q;
	assign stat_present = present_q;
	assign stat_mode = mode_q;

	// Two-entry receive buffer absorbs beats while storage is busy
	tsb_buf2 #(.WIDTH(MSG_W), .DEPTH(2)) u_rx_buf (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.in_data(link.up_msg),
		.in_valid(link.up_valid),
		.in_ready(link.up_ready),
		.out_data(f_msg),
		.out_valid(f_valid),
		.out_ready(f_ready)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Network settings: local on station zero, learned from tokens elsewhere
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_q <= '0;
			max_q <= '0;
		end
		else if (state_q == S_START || (cycle_start && cfg_station == '0))
		begin
			mode_q <= cfg_mode;
			max_q <= cfg_max;
		end
		else if (tok_set)
		begin
			mode_q <= f_msg.data[TOK_MODE_LSB +: MODE_W];
			max_q <= f_msg.data[TOK_MAX_LSB +: 6];
		end
	end

	// Shared area storage; own window only from the user
	always_ff @(posedge core_clk)
	begin
		if (wr_ok)
		begin
			if (usr_bit)
				chunk_q[usr_addr[4:0]] <= usr_wdata;
			else
				word_q[usr_addr] <= usr_wdata;
		end
		else if (rx_store)
		begin
			if (rx_a[6])
				chunk_q[rx_a[4:0]] <= f_msg.data;
			else
				word_q[rx_a[5:0]] <= f_msg.data;
		end
	end

	// Item position within an incoming broadcast
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			rx_idx_q <= '0;
		else if (pop && f_msg.kind == TSB_DATA)
			rx_idx_q <= f_msg.last ? '0 : rx_idx_q + 6'h01;
	end

	// User read-back and refused-write pulse
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata_q <= '0;
			err_q <= 1'b0;
		end
		else
		begin
			rdata_q <= usr_bit ? chunk_q[usr_addr[4:0]] : word_q[usr_addr];
			err_q <= usr_wr && !wr_ok;
		end
	end

	// Token flag one cycle behind the sequencer, so the output is a flip-flop
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			token_q <= 1'b0;
		else
			token_q <= (state_q == S_TX);
	end

	// Line silence, used by backup masters to take over
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			sil_q <= '0;
		else if (pop || master_q)
			sil_q <= '0;
		else if (sil_q != '1)
			sil_q <= sil_q + 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Token sequencing and transmit path
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= S_START;
			master_q <= 1'b0;
			poll_q <= '0;
			item_q <= '0;
			tmr_q <= '0;
			dn_valid_q <= 1'b0;
			dn_msg_q <= '0;
		end
		else
		begin
			unique case (state_q)
				S_START:
				begin
					master_q <= (cfg_station == '0);
					state_q <= (cfg_station == '0) ? S_TX : S_IDLE;
				end
				S_IDLE:
				begin
					item_q <= '0;
					if (own_ok && sil_q >= sil_lim)
					begin
						master_q <= 1'b1;
						state_q <= S_TX;
					end
					else if (tok_me && own_ok)
						state_q <= S_TX;
				end
				S_TX:
				begin
					if (!dn_valid_q || link.dn_ready)
					begin
						if (item_q <= items && own_ok)
						begin
							dn_valid_q <= 1'b1;
							dn_msg_q <= '{TSB_DATA, cfg_station, cfg_station,
								tx_a[6] ? chunk_q[tx_a[4:0]] : word_q[tx_a[5:0]],
								item_q == items};
							item_q <= item_q + 6'h01;
						end
						else
						begin
							dn_valid_q <= 1'b0;
							poll_q <= '0;
							state_q <= master_q ? S_NEXT : S_IDLE;
						end
					end
				end
				S_NEXT:
				begin
					item_q <= '0;
					if (!master_q)
						state_q <= S_IDLE;
					else if (poll_q >= lim)
						state_q <= S_TX;
					else if (poll_q == {1'b0, cfg_station})
						poll_q <= poll_q + 6'h01;
					else
						state_q <= S_TOK;
				end
				S_TOK:
				begin
					if (!dn_valid_q)
					begin
						dn_valid_q <= 1'b1;
						dn_msg_q <= '{TSB_TOKEN, cfg_station, poll_q[STN_W-1:0],
							DATA_W'({mode_q, max_q}), 1'b1};
					end
					else if (link.dn_ready)
					begin
						dn_valid_q <= 1'b0;
						tmr_q <= '0;
						state_q <= S_WAIT;
					end
				end
				S_WAIT:
				begin
					tmr_q <= tmr_q + 1'b1;
					if (wait_ok || wait_tmo)
					begin
						poll_q <= poll_q + 6'h01;
						state_q <= S_NEXT;
					end
				end
				default: state_q <= S_IDLE;
			endcase
			// Yield mastership to a lower-numbered station
			if (rx_yield && master_q && state_q != S_TX && state_q != S_TOK)
			begin
				master_q <= 1'b0;
				state_q <= S_IDLE;
			end
		end
	end

	// Network status flags
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			present_q <= '0;
			net_ok_q <= 1'b0;
		end
		else
		begin
			for (int i = 0; i < MAX_SINGLE; i++)
			begin
				if (rx_done && f_msg.src == STN_W'(i))
					present_q[i] <= 1'b1;
				else if (wait_tmo && poll_q == 6'(i))
					present_q[i] <= 1'b0;
				else if (i == int'(cfg_station))
					present_q[i] <= own_ok;
			end
			net_ok_q <= ((present_q & lim_mask) == lim_mask) && lim != '0;
		end
	end
endmodule

// ===== tb/tsb_monitor.sv
// Link monitor: handshake and token order between station and peer.
// Assumes station zero is master and the only sender on the down channel.
`timescale 1ns/1ns
module tsb_monitor
	import tsb_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire tsb_msg_t dn_msg,
	input wire logic dn_valid,
	input wire logic dn_ready,
	input wire tsb_msg_t up_msg,
	input wire logic up_valid,
	input wire logic up_ready
);
	logic dn_tok;
	logic dn_mid_q;
	logic up_mid_q;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	// Token offered on the down channel
	assign dn_tok = dn_valid && dn_msg.kind == TSB_TOKEN;

	// Open broadcasts; a token inside one would cut it short
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			dn_mid_q <= 1'b0;
		else if (dn_valid && dn_ready && dn_msg.kind == TSB_DATA)
			dn_mid_q <= !dn_msg.last;
	end
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			up_mid_q <= 1'b0;
		else if (up_valid && up_ready)
			up_mid_q <= !up_msg.last;
	end

	////////////////////////////////////////////////////////////////////////////////
	property p_dn_hold;
		dn_valid && !dn_ready |=> dn_valid && $stable(dn_msg);
	endproperty
	a_dn_hold: assert property (p_dn_hold)
		else $error("down beat changed before taken");
	property p_up_hold;
		up_valid && !up_ready |=> up_valid && $stable(up_msg);
	endproperty
	a_up_hold: assert property (p_up_hold)
		else $error("up beat changed before taken");
	property p_up_no_tok;
		up_valid |-> up_msg.kind == TSB_DATA;
	endproperty
	a_up_no_tok: assert property (p_up_no_tok)
		else $error("slave passed a token");
	property p_tok_slave;
		dn_tok |-> dn_msg.dst != 5'h00;
	endproperty
	a_tok_slave: assert property (p_tok_slave)
		else $error("token sent to the master itself");
	property p_tok_max;
		dn_tok |-> {1'b0, dn_msg.dst} < dn_msg.data[5:0];
	endproperty
	a_tok_max: assert property (p_tok_max)
		else $error("token beyond station count");
	property p_dn_src;
		dn_valid && dn_msg.kind == TSB_DATA |-> dn_msg.src == 5'h00;
	endproperty
	a_dn_src: assert property (p_dn_src)
		else $error("down data not from the master");
	property p_tok_after_last;
		dn_mid_q |-> !dn_tok;
	endproperty
	a_tok_after_last: assert property (p_tok_after_last)
		else $error("token inside own broadcast");
	property p_tok_wait_answer;
		up_mid_q |-> !dn_tok;
	endproperty
	a_tok_wait_answer: assert property (p_tok_wait_answer)
		else $error("token while slave still sends");
	property p_tok_gap;
		dn_tok && dn_ready |=> !dn_tok [*2];
	endproperty
	a_tok_gap: assert property (p_tok_gap)
		else $error("tokens back to back");
	property p_up_after_tok;
		dn_tok && dn_ready |=> !up_valid;
	endproperty
	a_up_after_tok: assert property (p_up_after_tok)
		else $error("answer too soon after token");
endmodule

// ===== tb/token_shared_area_bus_tb_top.sv
// Bench: station zero and one peer station joined by one link.
// Assumes 10 MHz clock; poll and silence counts are shortened.
`timescale 1ns/1ns
module token_shared_area_bus_tb_top;
	import tsb_pkg::*;
	localparam int POLL = 400;
	localparam logic [4:0] MD[13] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
		5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d};
	localparam logic [5:0] FW[13] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00,
		6'h00, 6'h00, 6'h20, 6'h20, 6'h20, 6'h20};
	localparam logic [5:0] NW[13] = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h02, 6'h04,
		6'h08, 6'h10, 6'h02, 6'h04, 6'h08, 6'h10};
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [MODE_W-1:0] cfg_mode = 5'h03;
	logic [5:0] usr_addr = 6'h00;
	logic usr_wr = 1'b0;
	logic usr_bit = 1'b0;
	logic tx_valid = 1'b0;
	logic [DATA_W-1:0] usr_wdata = 16'h0000;
	logic [DATA_W-1:0] tx_data = 16'h0000;
	logic usr_wr_err, tx_ready, tok_mine, stat_master, stat_token, stat_net_ok;
	logic [DATA_W-1:0] usr_rdata;
	logic [MAX_SINGLE-1:0] stat_present;
	logic [MODE_W-1:0] stat_mode;
	logic rx_valid;
	tsb_msg_t rx_msg;
	int mismatches = 0;
	int check_count = 0;
	tsb_msg_t dq[$];
	tsb_msg_t uq[$];
	tsb_link lnk();

	tsb_station #(.POLL_CYCLES(POLL), .SILENCE_CYCLES(1000)) u_tsb_station (.core_clk(core_clk),
		.rst_n(rst_n), .link(lnk.station), .cfg_station(5'h00), .cfg_mode(cfg_mode),
		.cfg_max(6'h02), .usr_wr(usr_wr), .usr_bit(usr_bit), .usr_addr(usr_addr),
		.usr_wdata(usr_wdata), .usr_wr_err(usr_wr_err), .usr_rdata(usr_rdata),
		.stat_master(stat_master), .stat_token(stat_token), .stat_net_ok(stat_net_ok),
		.stat_present(stat_present), .stat_mode(stat_mode));
	tsb_peer u_tsb_peer (.core_clk(core_clk), .rst_n(rst_n), .link(lnk.peer),
		.station_no(5'h01), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
		.rx_valid(rx_valid), .rx_msg(rx_msg), .tok_mine(tok_mine));
	tsb_monitor u_tsb_monitor (.core_clk(core_clk), .rst_n(rst_n), .dn_msg(lnk.dn_msg),
		.dn_valid(lnk.dn_valid), .dn_ready(lnk.dn_ready), .up_msg(lnk.up_msg),
		.up_valid(lnk.up_valid), .up_ready(lnk.up_ready));

	// Clock and hang guard; the guard far exceeds a few poll rounds
	initial
		forever #50 core_clk = ~core_clk;
	initial
	begin
		#2000000;
		mismatches++;
		stop_test;
	end

	// Every beat taken on either channel, as seen on the wire
	always @(posedge core_clk)
	begin
		if (lnk.dn_valid === 1'b1 && lnk.dn_ready === 1'b1)
			dq.push_back(lnk.dn_msg);
		if (lnk.up_valid === 1'b1 && lnk.up_ready === 1'b1)
			uq.push_back(lnk.up_msg);
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		if (mismatches == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Write, then expect refusal or read back the stored value
	task automatic wr(input logic b, input logic [5:0] a, input logic [15:0] d, input logic e);
		logic seen;
		usr_bit = b;
		usr_addr = a;
		usr_wdata = d;
		usr_wr = 1'b1;
		tick(1);
		usr_wr = 1'b0;
		seen = usr_wr_err;
		tick(1);
		chk(seen | usr_wr_err, e);
		if (!e)
			chk(usr_rdata, d);
	endtask
	task automatic rd(input logic b, input logic [5:0] a, input logic [15:0] e);
		usr_bit = b;
		usr_addr = a;
		tick(2);
		chk(usr_rdata, e);
	endtask
	task automatic wait_tok;
		for (int i = 0; i < 2000 && tok_mine !== 1'b1; i++)
			tick(1);
		chk(tok_mine, 1'b1);
	endtask
	// Peer answers its token; valid held up between items
	task automatic psend(input int n);
		for (int i = 0; i < n; i++)
		begin
			tx_valid = 1'b1;
			tx_data = 16'h1000 + 16'(i);
			for (int j = 0; j < 100 && tx_ready !== 1'b1; j++)
				tick(1);
			tick(1);
		end
		tx_valid = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Master starts with the token; next broadcast carries own window
	task automatic t_bcast;
		tick(3);
		chk(stat_token, 1'b1);
		chk(stat_master, 1'b1);
		wr(1'b0, 6'h00, 16'ha5a5, 1'b0);
		wr(1'b0, 6'h07, 16'h5a07, 1'b0);
		wr(1'b1, 6'h03, 16'hb003, 1'b0);
		wr(1'b0, 6'h08, 16'h0bad, 1'b1);
		wr(1'b1, 6'h04, 16'h0bad, 1'b1);
		wait_tok;
		chk(dq[$].kind, TSB_TOKEN);
		chk(dq[$].dst, 5'h01);
		chk(dq[$].data[10:0], {5'h03, 6'h02});
		dq.delete();
		psend(12);
		for (int i = 0; i < 500 && dq.size() < 12; i++)
			tick(1);
		chk({rx_valid, rx_msg.data, rx_msg.last}, {1'b1, 16'hb003, 1'b1});
		chk(dq[0].data, 16'ha5a5);
		chk(dq[7].data, 16'h5a07);
		chk(dq[11].data, 16'hb003);
		chk({dq[10].last, dq[11].last}, 2'b01);
		for (int i = 0; i < 12; i++)
			chk({dq[i].kind, dq[i].src}, {TSB_DATA, 5'h00});
		chk(uq.size(), 12);
		chk({uq[0].src, uq[0].data, uq[11].last}, {5'h01, 16'h1000, 1'b1});
	endtask
	// Peer's broadcast lands in its read-only receive window
	task automatic t_store;
		rd(1'b0, 6'h08, 16'h1000);
		rd(1'b0, 6'h0f, 16'h1007);
		rd(1'b1, 6'h07, 16'h100b);
		chk({stat_present[1:0], stat_net_ok, stat_mode}, {3'h7, 5'h03});
	endtask
	// Silent peer: master times out and keeps exchanging
	task automatic t_drop;
		int i;
		wait_tok;
		dq.delete();
		for (i = 0; i < 2000 && dq.size() == 0; i++)
			tick(1);
		chk(i >= POLL - 5 && i <= POLL + 60, 1'b1);
		chk({dq[0].kind, dq[0].src}, {TSB_DATA, 5'h00});
		chk({stat_present[1], stat_net_ok}, 2'b00);
	endtask
	// Own window edges per refresh mode; a new mode applies at the next cycle start
	task automatic t_modes;
		wait_tok;
		for (int i = 0; i < 13; i++)
		begin
			cfg_mode = MD[i];
			for (int j = 0; j < 1000 && stat_mode !== MD[i]; j++)
				tick(1);
			chk(stat_mode, MD[i]);
			wr(1'b0, FW[i] + NW[i] - 6'h01, 16'h7700 + 16'(i), 1'b0);
			wr(1'b0, FW[i] + NW[i], 16'h0bad, 1'b1);
			wr(1'b1, (FW[i] + NW[i]) / 2 - 6'h01, 16'h7800, 1'b0);
			wr(1'b1, (FW[i] + NW[i]) / 2, 16'h0bad, 1'b1);
		end
		cfg_mode = 5'h03;
		tick(2);
	endtask

	// Main sequence: reset for ten cycles, then the scenarios
	initial
	begin
		repeat (10) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		t_bcast;
		t_store;
		t_drop;
		t_modes;
		stop_test;
	end
endmodule
